// >>> core/syc_channel_config.sv
// register bank and wishbone slave for synthesizer channel and ook ramp setup
`timescale 1ns/100ps
module syc_channel_config (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic ook_mode_i,
    input wire logic ook_rx_i,
    output logic [1:0] ramp_code_o,
    output logic [2:0] vco_band_o,
    output logic bank_sel_o,
    output logic [7:0] active_ref_div_o,
    output logic [7:0] active_prescale_o,
    output logic [7:0] active_swallow_o,
    output logic [14:0] feedback_count_o,
    output logic [8:0] ref_count_o,
    output logic [6:0] offset_khz_o
);
    // ************************************************************
    // bus handshake
    // ************************************************************
    syc_pkg::syc_bus_t state_r;
    syc_pkg::syc_bus_t state_nxt;
    logic [31:0] dat_r;
    logic [31:0] dat_nxt;
    logic [6:0] offset_r;
    logic [6:0] offset_nxt;
    logic req;
    logic take;
    logic wr_take;
    logic [3:0] idx;
    logic idx_hi_ok;
    logic lane0;

    // a request is taken once; ack follows one cycle later for one cycle
    assign req = wb_cyc_i && wb_stb_i;
    assign take = req && (state_r == syc_pkg::SYC_IDLE);
    assign wr_take = take && wb_we_i && lane0;
    assign lane0 = wb_sel_i[0];
    assign idx = wb_adr_i[5:2];
    assign idx_hi_ok = (wb_adr_i[7:6] == 2'b00);

    // answer state walk
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            syc_pkg::SYC_IDLE: begin
                if (take) begin
                    state_nxt = syc_pkg::SYC_ANSWER;
                end
            end
            syc_pkg::SYC_ANSWER: begin
                state_nxt = syc_pkg::SYC_IDLE;
            end
            default: begin
                state_nxt = syc_pkg::SYC_IDLE;
            end
        endcase
    end

    assign wb_ack_o = (state_r == syc_pkg::SYC_ANSWER);

    // ************************************************************
    // address decode
    // ************************************************************
    logic hit_main;
    logic hit_mod;
    logic [syc_pkg::NUM_DIV_REGS-1:0] hit_div;
    logic [3:0] div_idx [syc_pkg::NUM_DIV_REGS];
    logic [7:0] div_q [syc_pkg::NUM_DIV_REGS];
    logic [7:0] main_q;
    logic [7:0] mod_q;

    assign hit_main = idx_hi_ok && (idx == syc_pkg::IDX_MAIN_CONFIG_BAND);
    assign hit_mod = idx_hi_ok && (idx == syc_pkg::IDX_MOD_RAMP_BANK);
    assign div_idx[0] = syc_pkg::IDX_BANK_A_REF;
    assign div_idx[1] = syc_pkg::IDX_BANK_A_PRE;
    assign div_idx[2] = syc_pkg::IDX_BANK_A_SWA;
    assign div_idx[3] = syc_pkg::IDX_BANK_B_REF;
    assign div_idx[4] = syc_pkg::IDX_BANK_B_PRE;
    assign div_idx[5] = syc_pkg::IDX_BANK_B_SWA;

    // ************************************************************
    // registers
    // ************************************************************
    // band select, only bits 4..2 are stored
    syc_reg8 #(
        .RST_VAL(syc_pkg::MAIN_CONFIG_RST),
        .WMASK(syc_pkg::MAIN_CONFIG_WMASK)
    ) u_main (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .we_i(wr_take && hit_main),
        .d_i(wb_dat_i[7:0]),
        .q_o(main_q)
    );

    // ramp code in 7..6, bank select in bit 0
    syc_reg8 #(
        .RST_VAL(syc_pkg::MOD_RAMP_RST),
        .WMASK(syc_pkg::MOD_RAMP_WMASK)
    ) u_mod (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .we_i(wr_take && hit_mod),
        .d_i(wb_dat_i[7:0]),
        .q_o(mod_q)
    );

    // the two divider banks, written any time, active or idle
    genvar g;
    generate
        for (g = 0; g < syc_pkg::NUM_DIV_REGS; g++) begin : g_div
            assign hit_div[g] = idx_hi_ok && (idx == div_idx[g]);
            syc_reg8 #(
                .RST_VAL(syc_pkg::DIV_RST),
                .WMASK(8'hFF)
            ) u_div (
                .clk_i(clk_i),
                .rst_i(rst_i),
                .we_i(wr_take && hit_div[g]),
                .d_i(wb_dat_i[7:0]),
                .q_o(div_q[g])
            );
        end
    endgenerate

    // ************************************************************
    // read mux
    // ************************************************************
    logic [7:0] rd_byte;
    logic [7:0] div_rd;

    always_comb begin
        div_rd = 8'h00;
        for (int i = 0; i < syc_pkg::NUM_DIV_REGS; i++) begin
            if (hit_div[i]) begin
                div_rd = div_q[i];
            end
        end
    end

    // unmapped indices read as zero
    assign rd_byte = hit_main ? main_q : (hit_mod ? mod_q : div_rd);
    assign dat_nxt = (take && !wb_we_i) ? {24'h00_0000, rd_byte} : dat_r;

    // ************************************************************
    // synthesizer side
    // ************************************************************
    assign ramp_code_o = mod_q[syc_pkg::RAMP_MSB:syc_pkg::RAMP_LSB];
    assign vco_band_o = main_q[syc_pkg::BAND_MSB:syc_pkg::BAND_LSB];
    assign bank_sel_o = mod_q[syc_pkg::BANK_SEL_BIT];

    syc_bank_mux u_mux (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .bank_sel_i(mod_q[syc_pkg::BANK_SEL_BIT]),
        .ref_a_i(div_q[0]),
        .pre_a_i(div_q[1]),
        .swa_a_i(div_q[2]),
        .ref_b_i(div_q[3]),
        .pre_b_i(div_q[4]),
        .swa_b_i(div_q[5]),
        .ref_o(active_ref_div_o),
        .pre_o(active_prescale_o),
        .swa_o(active_swallow_o),
        .feedback_count_o(feedback_count_o),
        .ref_count_o(ref_count_o)
    );

    // offset subtracted from the divider result in ook
    assign offset_nxt = !ook_mode_i ? syc_pkg::NO_OFFSET_KHZ :
        (ook_rx_i ? syc_pkg::DEVIATION_OFFSET_KHZ
                  : syc_pkg::SECOND_IF_OFFSET_KHZ);

    // bus state, read data and offset
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_r <= syc_pkg::SYC_IDLE;
            dat_r <= 32'h0000_0000;
            offset_r <= syc_pkg::NO_OFFSET_KHZ;
        end else begin
            state_r <= state_nxt;
            dat_r <= dat_nxt;
            offset_r <= offset_nxt;
        end
    end

    assign wb_dat_o = dat_r;
    assign offset_khz_o = offset_r;

    // ************************************************************
    // checks
    // ************************************************************
    ack_one_cycle_a: assert property (@(posedge clk_i) disable iff (rst_i)
        take |=> wb_ack_o ##1 !wb_ack_o)
        else $error("ack not a single cycle after request");
    ramp_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_take && hit_mod |=> ramp_code_o == $past(wb_dat_i[7:6]))
        else $error("ramp code not taken from bits 7..6");
    band_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_take && hit_main |=> vco_band_o == $past(wb_dat_i[4:2]))
        else $error("vco band not taken from bits 4..2");
    bank_b_follow_a: assert property (@(posedge clk_i) disable iff (rst_i)
        bank_sel_o && $stable(bank_sel_o) ##1 bank_sel_o
        |-> active_prescale_o == $past(div_q[4]))
        else $error("bank b selected but prescale not from bank b");
    // a classic master needs three cycles from one take to the next
    div_readback_a: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_take && hit_div[3] ##3 take && !wb_we_i && hit_div[3]
        |=> wb_dat_o[7:0] == $past(wb_dat_i[7:0], 4))
        else $error("bank b reference divider readback wrong");
    ook_offset_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ook_mode_i |=> offset_khz_o == 7'd100)
        else $error("ook offset not 100 kHz");
    fsk_offset_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !ook_mode_i |=> offset_khz_o == 7'd0)
        else $error("fsk channel carries an offset");
    switch_time_a: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(bank_sel_o) |-> ##1 active_ref_div_o == div_q[3])
        else $error("reference divider not switched with the bank");

    bank_switch_c: cover property (@(posedge clk_i) disable iff (rst_i) $rose(bank_sel_o));
    idle_write_c: cover property (@(posedge clk_i) disable iff (rst_i)
        wr_take && hit_div[3] && !bank_sel_o);
    read_c: cover property (@(posedge clk_i) disable iff (rst_i) take && !wb_we_i);
endmodule // syc_channel_config

// >>> core/syc_pkg.sv
// constants and types shared by the synthesizer channel configuration block
package syc_pkg;

    // ************************************************************
    // register indices, byte address is four times the index
    // ************************************************************
    localparam logic [3:0] IDX_MAIN_CONFIG_BAND = 4'h0;
    localparam logic [3:0] IDX_MOD_RAMP_BANK = 4'h5;
    localparam logic [3:0] IDX_BANK_A_REF = 4'h6;
    localparam logic [3:0] IDX_BANK_A_PRE = 4'h7;
    localparam logic [3:0] IDX_BANK_A_SWA = 4'h8;
    localparam logic [3:0] IDX_BANK_B_REF = 4'h9;
    localparam logic [3:0] IDX_BANK_B_PRE = 4'hA;
    localparam logic [3:0] IDX_BANK_B_SWA = 4'hB;
    localparam int NUM_DIV_REGS = 6;

    // ************************************************************
    // field positions and reset values
    // ************************************************************
    localparam int BAND_LSB = 2;
    localparam int BAND_MSB = 4;
    localparam int RAMP_LSB = 6;
    localparam int RAMP_MSB = 7;
    localparam int BANK_SEL_BIT = 0;
    localparam logic [7:0] MAIN_CONFIG_RST = 8'h00;
    localparam logic [7:0] MOD_RAMP_RST = 8'h00;
    localparam logic [7:0] DIV_RST = 8'h00;
    localparam logic [7:0] MAIN_CONFIG_WMASK = 8'h1C;
    localparam logic [7:0] MOD_RAMP_WMASK = 8'hC1;

    // ************************************************************
    // synthesizer arithmetic
    // ************************************************************
    localparam logic [14:0] PRESCALE_MULT = 15'h004B;  // 75
    localparam logic [14:0] ONE_15 = 15'h0001;
    localparam logic [8:0] ONE_9 = 9'h001;
    localparam logic [6:0] DEVIATION_OFFSET_KHZ = 7'h64;  // 100 kHz
    localparam logic [6:0] SECOND_IF_OFFSET_KHZ = 7'h64;  // 100 kHz
    localparam logic [6:0] NO_OFFSET_KHZ = 7'h00;

    // ************************************************************
    // ramp codes and vco bands
    // ************************************************************
    typedef enum logic [1:0] {
        SYC_RAMP_SHORTEST = 2'b00,
        SYC_RAMP_SHORT = 2'b01,
        SYC_RAMP_LONG = 2'b10,
        SYC_RAMP_LONGEST = 2'b11
    } syc_ramp_t;

    localparam logic [2:0] BAND_300_330 = 3'h0;
    localparam logic [2:0] BAND_470_510 = 3'h5;

    // ************************************************************
    // bus answer states
    // ************************************************************
    typedef enum logic [1:0] {
        SYC_IDLE = 2'b00,
        SYC_ANSWER = 2'b01
    } syc_bus_t;

endpackage

// >>> core/syc_reg8.sv
// one byte-wide software register with write mask and reset value
`timescale 1ns/100ps
module syc_reg8 #(
    parameter logic [7:0] RST_VAL = 8'h00,
    parameter logic [7:0] WMASK = 8'hFF
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic we_i,
    input wire logic [7:0] d_i,
    output logic [7:0] q_o
);
    logic [7:0] q_r;
    logic [7:0] q_nxt;

    // masked bits keep reading zero
    assign q_nxt = we_i ? (d_i & WMASK) : q_r;
    assign q_o = q_r;

    // storage
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q_r <= RST_VAL & WMASK;
        end else begin
            q_r <= q_nxt;
        end
    end
endmodule // syc_reg8

// >>> core/syc_bank_mux.sv
// picks the active divider bank and presents it to the synthesizer as one set
`timescale 1ns/100ps
module syc_bank_mux (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic bank_sel_i,
    input wire logic [7:0] ref_a_i,
    input wire logic [7:0] pre_a_i,
    input wire logic [7:0] swa_a_i,
    input wire logic [7:0] ref_b_i,
    input wire logic [7:0] pre_b_i,
    input wire logic [7:0] swa_b_i,
    output logic [7:0] ref_o,
    output logic [7:0] pre_o,
    output logic [7:0] swa_o,
    output logic [14:0] feedback_count_o,
    output logic [8:0] ref_count_o
);
    logic [7:0] ref_r;
    logic [7:0] pre_r;
    logic [7:0] swa_r;
    logic [14:0] fb_r;
    logic [8:0] rc_r;
    logic [7:0] ref_nxt;
    logic [7:0] pre_nxt;
    logic [7:0] swa_nxt;
    logic [14:0] fb_nxt;
    logic [8:0] rc_nxt;
    logic [14:0] pre_ext;

    // one select steers all three values, never a mix of banks
    assign ref_nxt = bank_sel_i ? ref_b_i : ref_a_i;
    assign pre_nxt = bank_sel_i ? pre_b_i : pre_a_i;
    assign swa_nxt = bank_sel_i ? swa_b_i : swa_a_i;

    // feedback divide 75*(p+1)+s and reference divide r+1
    assign pre_ext = {7'h00, pre_nxt};
    assign fb_nxt = 15'(syc_pkg::PRESCALE_MULT * (pre_ext + syc_pkg::ONE_15))
        + {7'h00, swa_nxt};
    assign rc_nxt = {1'b0, ref_nxt} + syc_pkg::ONE_9;

    // active set, loaded together each cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ref_r <= syc_pkg::DIV_RST;
            pre_r <= syc_pkg::DIV_RST;
            swa_r <= syc_pkg::DIV_RST;
            fb_r <= '0;
            rc_r <= '0;
        end else begin
            ref_r <= ref_nxt;
            pre_r <= pre_nxt;
            swa_r <= swa_nxt;
            fb_r <= fb_nxt;
            rc_r <= rc_nxt;
        end
    end

    assign ref_o = ref_r;
    assign pre_o = pre_r;
    assign swa_o = swa_r;
    assign feedback_count_o = fb_r;
    assign ref_count_o = rc_r;

    // ************************************************************
    // checks
    // ************************************************************
    idle_bank_quiet_a: assert property (@(posedge clk_i) disable iff (rst_i)
        $stable(bank_sel_i) && !bank_sel_i && $stable(ref_a_i) && $stable(pre_a_i)
        && $stable(swa_a_i) |=> $stable(ref_o) && $stable(pre_o) && $stable(swa_o))
        else $error("bank a output moved while only bank b could change");
    bank_set_whole_a: assert property (@(posedge clk_i) disable iff (rst_i)
        1'b1 |=> (ref_o == $past(ref_nxt)) && (pre_o == $past(pre_nxt))
        && (swa_o == $past(swa_nxt)))
        else $error("divider set drawn from mixed banks");
    // reset clears the counts to zero, so the first cycle after reset is skipped
    feedback_formula_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !$past(rst_i) |-> feedback_count_o == 15'(syc_pkg::PRESCALE_MULT
        * ({7'h00, pre_o} + syc_pkg::ONE_15)) + {7'h00, swa_o})
        else $error("feedback count does not match divider formula");
endmodule // syc_bank_mux

// >>> testbench/syc_channel_config_bench.sv
// self-checking bench for the synthesizer channel configuration block
`timescale 1ns/100ps
module syc_channel_config_bench;
    // ************************************************************
    // signals, clock, design instance
    // ************************************************************
    typedef struct packed {logic [7:0] adr; logic [7:0] wd; logic [7:0] rd;} syc_row_t;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0000_0000;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic ook_mode_i = 1'b0;
    logic ook_rx_i = 1'b0;
    logic [1:0] ramp_code_o;
    logic [2:0] vco_band_o;
    logic bank_sel_o;
    logic [7:0] active_ref_div_o;
    logic [7:0] active_prescale_o;
    logic [7:0] active_swallow_o;
    logic [14:0] feedback_count_o;
    logic [8:0] ref_count_o;
    logic [6:0] offset_khz_o;
    int fails = 0;
    int samples_checked = 0;
    logic [31:0] q;
    syc_row_t rows [10];
    logic [23:0] act_set;
    logic set_whole;

    // active divider set is always one whole bank
    assign act_set = {active_ref_div_o, active_prescale_o, active_swallow_o};
    assign set_whole = (act_set === 24'h6b2a1e) || (act_set === 24'h8f3a2d);

    // free-running 20 MHz clock
    always #25 clk_i = ~clk_i;

    syc_channel_config u_syc_channel_config (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ook_mode_i(ook_mode_i),
        .ook_rx_i(ook_rx_i), .ramp_code_o(ramp_code_o), .vco_band_o(vco_band_o),
        .bank_sel_o(bank_sel_o), .active_ref_div_o(active_ref_div_o),
        .active_prescale_o(active_prescale_o), .active_swallow_o(active_swallow_o),
        .feedback_count_o(feedback_count_o), .ref_count_o(ref_count_o),
        .offset_khz_o(offset_khz_o)
    );

    // ************************************************************
    // helpers
    // ************************************************************
    // byte address of a register index
    function automatic logic [7:0] adr_of(input logic [3:0] idx);
        return {2'b00, idx, 2'b00};
    endfunction

    // expected feedback count from prescale and swallow
    function automatic logic [14:0] fb_of(input logic [7:0] p, input logic [7:0] s);
        return 15'(75 * (int'(p) + 1) + int'(s));
    endfunction

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // one classic wishbone cycle, held until ack is sampled high
    task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [3:0] sel,
                           input logic [7:0] d, output logic [31:0] rdat);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_sel_i <= sel;
        wb_dat_i <= {24'h00_0000, d};
        @(posedge clk_i);
        while (wb_ack_o !== 1'b1 && n < 16) begin
            @(posedge clk_i);
            n++;
        end
        if (wb_ack_o !== 1'b1) begin
            fails++;
            $display("[ERR] wb_ack_o expected 1 seen %b", wb_ack_o);
        end
        rdat = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] adr, input logic [7:0] d);
        logic [31:0] dummy;
        wb_xfer(1'b1, adr, 4'h1, d, dummy);
    endtask

    task automatic chk_set(input logic [7:0] r, input logic [7:0] p, input logic [7:0] s);
        chk("active_ref_div_o", 32'(r), 32'(active_ref_div_o));
        chk("active_prescale_o", 32'(p), 32'(active_prescale_o));
        chk("active_swallow_o", 32'(s), 32'(active_swallow_o));
        chk("feedback_count_o", 32'(fb_of(p, s)), 32'(feedback_count_o));
        chk("ref_count_o", 32'(int'(r) + 1), 32'(ref_count_o));
    endtask

    task automatic end_sim;
        $display("mismatches %0d of %0d checks", fails, samples_checked);
        if (fails == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        // band 101 and bank a kept: no undefined band, no switch to an empty bank
        rows = '{'{8'h00, 8'hf7, 8'h14}, '{8'h14, 8'hfe, 8'hc0}, '{8'h0c, 8'haa, 8'h00},
                 '{8'h58, 8'h55, 8'h00}, '{8'h18, 8'h6b, 8'h6b}, '{8'h1c, 8'h2a, 8'h2a},
                 '{8'h20, 8'h1e, 8'h1e}, '{8'h24, 8'h77, 8'h77}, '{8'h28, 8'h22, 8'h22},
                 '{8'h2c, 8'h00, 8'h00}};
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        // reset values of every register and of ref_count_o
        foreach (rows[i]) begin
            wb_xfer(1'b0, rows[i].adr, 4'h1, 8'h00, q);
            chk("reset readback", 32'h0000_0000, q);
        end
        chk("ref_count_o", 32'h0000_0001, 32'(ref_count_o));
        // table rows: write, read back with masks and unmapped places
        foreach (rows[i]) begin
            wr(rows[i].adr, rows[i].wd);
            wb_xfer(1'b0, rows[i].adr, 4'h1, 8'h00, q);
            chk("register readback", 32'(rows[i].rd), q);
        end
        // write with lane 0 disabled stores nothing
        wb_xfer(1'b1, adr_of(syc_pkg::IDX_BANK_A_REF), 4'he, 8'h11, q);
        wb_xfer(1'b0, adr_of(syc_pkg::IDX_BANK_A_REF), 4'h1, 8'h00, q);
        chk("lane0 off write", 32'h0000_006b, q);
        // vco band codes 0 to 5
        for (int b = 0; b < 6; b++) begin
            wr(adr_of(syc_pkg::IDX_MAIN_CONFIG_BAND), {3'b000, 3'(b), 2'b00});
            repeat (2) @(posedge clk_i);
            chk("vco_band_o", 32'(b), 32'(vco_band_o));
        end
        // every ramp code, bank a selected
        for (int r = 0; r < 4; r++) begin
            wr(adr_of(syc_pkg::IDX_MOD_RAMP_BANK), {2'(r), 6'h00});
            repeat (3) @(posedge clk_i);
            chk("ramp_code_o", 32'(r), 32'(ramp_code_o));
        end
        chk("bank_sel_o", 32'h0000_0000, 32'(bank_sel_o));
        chk_set(8'h6b, 8'h2a, 8'h1e);
        // stage the next hop in idle bank b while bank a drives
        wr(adr_of(syc_pkg::IDX_BANK_B_REF), 8'h8f);
        chk_set(8'h6b, 8'h2a, 8'h1e);
        wr(adr_of(syc_pkg::IDX_BANK_B_PRE), 8'h3a);
        wr(adr_of(syc_pkg::IDX_BANK_B_SWA), 8'h2d);
        repeat (3) @(posedge clk_i);
        chk_set(8'h6b, 8'h2a, 8'h1e);
        // switch to bank b, the set must never be mixed
        fork
            wr(adr_of(syc_pkg::IDX_MOD_RAMP_BANK), 8'h01);
            repeat (6) begin
                @(negedge clk_i);
                chk("whole set", 32'h0000_0001, 32'(set_whole));
            end
        join
        chk("bank_sel_o", 32'h0000_0001, 32'(bank_sel_o));
        chk_set(8'h8f, 8'h3a, 8'h2d);
        // offset in fsk and both ook directions
        chk("offset fsk", 32'h0000_0000, 32'(offset_khz_o));
        @(posedge clk_i);
        ook_mode_i <= 1'b1;
        ook_rx_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        chk("offset ook rx", 32'(syc_pkg::DEVIATION_OFFSET_KHZ), 32'(offset_khz_o));
        ook_rx_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        chk("offset ook tx", 32'(syc_pkg::SECOND_IF_OFFSET_KHZ), 32'(offset_khz_o));
        // second reset in mid-run clears the bank select
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        wb_xfer(1'b0, adr_of(syc_pkg::IDX_MOD_RAMP_BANK), 4'h1, 8'h00, q);
        chk("mod reg after reset", 32'h0000_0000, q);
        chk("bank_sel_o", 32'h0000_0000, 32'(bank_sel_o));
        chk_set(8'h00, 8'h00, 8'h00);
        end_sim();
    end

    // watchdog, well beyond the few hundred cycles the tests need
    initial begin
        #(50 * 5000);
        fails++;
        $display("[ERR] watchdog expected done seen hang");
        end_sim();
    end
endmodule // syc_channel_config_bench
